// file: hw/gpib_listener_map.svh
// Constants for the listen-only bus interface: command codes and address fields.
`ifndef GPIB_LISTENER_MAP_SVH
`define GPIB_LISTENER_MAP_SVH
`define GL_CMD_MASK    8'h7F
`define GL_GRP_MASK    8'h60
`define GL_ADDR_MASK   8'h1F
`define GL_LISTEN_GRP  8'h20
`define GL_UNLISTEN    8'h3F
`define GL_GO_LOCAL    8'h01
`define GL_SEL_CLEAR   8'h04
`define GL_TRIGGER     8'h08
`define GL_ALL_CLEAR   8'h14
`define GL_ADDR_W      5
`define GL_ADDR_RST    5'h03
`endif

// file: hw/gpib_listener_pkg.sv
// Types shared by the listen-only bus interface modules.
package gpib_listener_pkg;
	typedef enum logic [1:0] {
		acc_off  = 2'b00,
		acc_nrdy = 2'b01,
		acc_rdy  = 2'b10,
		acc_hold = 2'b11
	} acc_state_t;
endpackage : gpib_listener_pkg

// file: hw/acceptor_if.sv
// Link between the listener control logic and the acceptor handshake engine.
interface acceptor_if;
	logic       active;
	logic       ready;
	logic       clear;
	logic       byte_stb;
	logic [7:0] byte_data;
	logic       byte_eoi;
	logic       byte_atn;
	modport ctl (output active, ready, clear, input byte_stb, byte_data, byte_eoi, byte_atn);
	modport acc (input active, ready, clear, output byte_stb, byte_data, byte_eoi, byte_atn);
endinterface : acceptor_if

// file: hw/acceptor_handshake.sv
// Three-wire acceptor handshake engine with byte capture.
module acceptor_handshake (
	input  wire logic  ref_clk_i,    // System clock.
	input  wire logic  nrst_i,       // Asynchronous reset, active low.
	input  wire logic  ce_i,         // Clock enable.
	input  wire logic  dav_i,        // Data valid, high is true.
	input  wire logic  eoi_i,        // End of message mark.
	input  wire logic  atn_i,        // Attention.
	input  wire logic [7:0] dio_i,   // Data lines.
	output logic       nrfd_oe_n_o,  // Low while pulling not-ready-for-data low.
	output logic       ndac_oe_n_o,  // Low while pulling not-data-accepted low.
	acceptor_if.acc    bus           // Control side.
);
	gpib_listener_pkg::acc_state_t st_r;
	gpib_listener_pkg::acc_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			gpib_listener_pkg::acc_off: begin
				if (bus.active) st_nxt = gpib_listener_pkg::acc_nrdy;
			end
			gpib_listener_pkg::acc_nrdy: begin
				if (!bus.active) st_nxt = gpib_listener_pkg::acc_off;
				else if (bus.ready && !dav_i) st_nxt = gpib_listener_pkg::acc_rdy;
			end
			gpib_listener_pkg::acc_rdy: begin
				if (!bus.active) st_nxt = gpib_listener_pkg::acc_off;
				else if (dav_i) st_nxt = gpib_listener_pkg::acc_hold;
			end
			gpib_listener_pkg::acc_hold: begin
				if (!dav_i) st_nxt = bus.active ? gpib_listener_pkg::acc_nrdy
				                                : gpib_listener_pkg::acc_off;
			end
			default: st_nxt = gpib_listener_pkg::acc_off;
		endcase
		if (bus.clear) st_nxt = gpib_listener_pkg::acc_off;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) st_r <= gpib_listener_pkg::acc_off;
		else if (ce_i) st_r <= st_nxt;
	end

	// The byte is caught on the same edge that releases not-data-accepted, so the sender
	// can never see acceptance before the register holds the byte.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus.byte_stb  <= 1'b0;
			bus.byte_data <= 8'h00;
			bus.byte_eoi  <= 1'b0;
			bus.byte_atn  <= 1'b0;
		end else if (ce_i) begin
			bus.byte_stb <= 1'b0;
			if (st_r == gpib_listener_pkg::acc_rdy && st_nxt == gpib_listener_pkg::acc_hold) begin
				bus.byte_stb  <= 1'b1;
				bus.byte_data <= dio_i;
				bus.byte_eoi  <= eoi_i;
				bus.byte_atn  <= atn_i;
			end
		end
	end

	assign nrfd_oe_n_o = (st_r == gpib_listener_pkg::acc_off) || (st_r == gpib_listener_pkg::acc_rdy);
	assign ndac_oe_n_o = (st_r == gpib_listener_pkg::acc_off) || (st_r == gpib_listener_pkg::acc_hold);

	property p_nrfd_stays;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && st_r == gpib_listener_pkg::acc_rdy && !dav_i && bus.active && !bus.clear)
			|=> nrfd_oe_n_o;
	endproperty
	a_nrfd_stays: assert property (p_nrfd_stays) else $error("ready released before data valid");

	property p_accept;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && st_r == gpib_listener_pkg::acc_rdy && dav_i && bus.active && !bus.clear)
			|=> (ndac_oe_n_o && !nrfd_oe_n_o);
	endproperty
	a_accept: assert property (p_accept) else $error("byte not accepted after data valid");

	property p_ndac_again;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && st_r == gpib_listener_pkg::acc_hold && !dav_i && bus.active && !bus.clear)
			|=> !ndac_oe_n_o;
	endproperty
	a_ndac_again: assert property (p_ndac_again) else $error("accepted line not pulled low");

	property p_latch;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && st_r == gpib_listener_pkg::acc_rdy && dav_i && bus.active && !bus.clear)
			|=> (bus.byte_stb && bus.byte_data == $past(dio_i) && ndac_oe_n_o);
	endproperty
	a_latch: assert property (p_latch) else $error("byte not latched with acceptance");

	property p_wait_ready;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && st_r == gpib_listener_pkg::acc_nrdy && !bus.ready && bus.active && !bus.clear)
			|=> !nrfd_oe_n_o;
	endproperty
	a_wait_ready: assert property (p_wait_ready) else $error("ready shown while not ready");
endmodule : acceptor_handshake

// file: hw/gpib_listener.sv
// Listen-only parallel instrument bus port: addressing, command decode and byte delivery.
`include "gpib_listener_map.svh"
module gpib_listener #(
	parameter logic [`GL_ADDR_W-1:0] ADDR_DEFAULT = `GL_ADDR_RST  // Address before strap is read.
) (
	input  wire logic        ref_clk_i,     // System clock, 100 MHz.
	input  wire logic        nrst_i,        // Asynchronous reset, active low.
	input  wire logic        ce_i,          // Clock enable, freezes all state when low.
	input  wire logic [`GL_ADDR_W-1:0] addr_strap_i, // Own listen address, 0 to 30.
	input  wire logic [7:0]  dio_i,         // Data lines, high is true.
	input  wire logic        dav_i,         // Data valid.
	input  wire logic        eoi_i,         // End or identify.
	input  wire logic        atn_i,         // Attention.
	input  wire logic        ifc_i,         // Interface clear.
	input  wire logic        ren_i,         // Remote enable.
	input  wire logic        user_ready_i,  // Consumer can take a device byte.
	output logic             nrfd_o,        // Not-ready-for-data drive level, always low.
	output logic             nrfd_oe_n_o,   // Low while pulling not-ready-for-data.
	output logic             ndac_o,        // Not-data-accepted drive level, always low.
	output logic             ndac_oe_n_o,   // Low while pulling not-data-accepted.
	output logic [7:0]       data_o,        // Last device byte.
	output logic             data_valid_o,  // One-cycle pulse with a device byte.
	output logic             data_end_o,    // Byte carried the end mark.
	output logic             listening_o,   // Addressed to listen.
	output logic             remote_o,      // Remote operation.
	output logic             dev_clear_o,   // One-cycle device clear pulse.
	output logic             trigger_o      // One-cycle trigger pulse.
);
	acceptor_if acc_if ();

	logic [`GL_ADDR_W-1:0] addr_r;
	logic                  addr_taken_r;
	logic                  listening_r;
	logic                  remote_r;
	logic [7:0]            cmd;

	function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] code);
		cmd_is = ((b & `GL_CMD_MASK) == code);
	endfunction : cmd_is

	assign cmd = acc_if.byte_data & `GL_CMD_MASK;

	// Under attention the port takes part regardless of addressing; device data waits
	// for the consumer, commands never do.
	assign acc_if.active = atn_i || listening_r;
	assign acc_if.ready  = atn_i || user_ready_i;
	assign acc_if.clear  = ifc_i;

	acceptor_handshake u_acceptor (
		.ref_clk_i   (ref_clk_i),
		.nrst_i      (nrst_i),
		.ce_i        (ce_i),
		.dav_i       (dav_i),
		.eoi_i       (eoi_i),
		.atn_i       (atn_i),
		.dio_i       (dio_i),
		.nrfd_oe_n_o (nrfd_oe_n_o),
		.ndac_oe_n_o (ndac_oe_n_o),
		.bus         (acc_if.acc)
	);

	assign nrfd_o = 1'b0;
	assign ndac_o = 1'b0;

	// The strap is read on the first enabled edge after reset rather than under reset.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_r       <= ADDR_DEFAULT;
			addr_taken_r <= 1'b0;
		end else if (ce_i && !addr_taken_r) begin
			addr_r       <= addr_strap_i;
			addr_taken_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) listening_r <= 1'b0;
		else if (ce_i) begin
			if (ifc_i) listening_r <= 1'b0;
			else if (acc_if.byte_stb && acc_if.byte_atn) begin
				if (cmd_is(acc_if.byte_data, `GL_UNLISTEN)) listening_r <= 1'b0;
				else if (cmd == (`GL_LISTEN_GRP | {3'b000, addr_r})) listening_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) remote_r <= 1'b0;
		else if (ce_i) begin
			if (!ren_i) remote_r <= 1'b0;
			else if (acc_if.byte_stb && acc_if.byte_atn) begin
				if (cmd == (`GL_LISTEN_GRP | {3'b000, addr_r})) remote_r <= 1'b1;
				else if (listening_r && cmd_is(acc_if.byte_data, `GL_GO_LOCAL)) remote_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dev_clear_o <= 1'b0;
			trigger_o   <= 1'b0;
		end else if (ce_i) begin
			dev_clear_o <= acc_if.byte_stb && acc_if.byte_atn && !ifc_i
			               && (cmd_is(acc_if.byte_data, `GL_ALL_CLEAR)
			               || (listening_r && cmd_is(acc_if.byte_data, `GL_SEL_CLEAR)));
			trigger_o   <= acc_if.byte_stb && acc_if.byte_atn && !ifc_i && listening_r
			               && cmd_is(acc_if.byte_data, `GL_TRIGGER);
		end
	end

	// A byte with attention false is device data; its end mark closes the message.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data_o       <= 8'h00;
			data_valid_o <= 1'b0;
			data_end_o   <= 1'b0;
		end else if (ce_i) begin
			data_valid_o <= 1'b0;
			if (acc_if.byte_stb && !acc_if.byte_atn && listening_r && !ifc_i) begin
				data_o       <= acc_if.byte_data;
				data_valid_o <= 1'b1;
				data_end_o   <= acc_if.byte_eoi;
			end
		end
	end

	assign listening_o = listening_r;
	assign remote_o    = remote_r;

	property p_ignore;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && acc_if.byte_stb && (acc_if.byte_atn || !listening_r)) |=> !data_valid_o;
	endproperty
	a_ignore: assert property (p_ignore) else $error("data passed while not addressed");

	property p_deliver;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && acc_if.byte_stb && !acc_if.byte_atn && listening_r && !ifc_i)
			|=> (data_valid_o && data_o == $past(acc_if.byte_data));
	endproperty
	a_deliver: assert property (p_deliver) else $error("addressed byte not delivered");

	property p_end_mark;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && acc_if.byte_stb && !acc_if.byte_atn && listening_r && !ifc_i)
			|=> (data_end_o == $past(acc_if.byte_eoi));
	endproperty
	a_end_mark: assert property (p_end_mark) else $error("end mark not reported");

	property p_atn_engage;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && atn_i && !ifc_i && nrfd_oe_n_o && ndac_oe_n_o && !dav_i) |=> !ndac_oe_n_o;
	endproperty
	a_atn_engage: assert property (p_atn_engage) else $error("attention byte not handshaken");

	property p_go_local;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && remote_r && !ren_i) |=> !remote_o ##1 (!remote_o || ren_i || !ce_i);
	endproperty
	a_go_local: assert property (p_go_local) else $error("remote kept without enable");

	property p_clear;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && ifc_i) |=> (!listening_o && nrfd_oe_n_o && ndac_oe_n_o);
	endproperty
	a_clear: assert property (p_clear) else $error("interface clear not obeyed");

	property p_listen_set;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && acc_if.byte_stb && acc_if.byte_atn && !ifc_i
			&& cmd == (`GL_LISTEN_GRP | {3'b000, addr_r})) |=> listening_o;
	endproperty
	a_listen_set: assert property (p_listen_set) else $error("listen address ignored");

	property p_unlisten;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && acc_if.byte_stb && acc_if.byte_atn && cmd == `GL_UNLISTEN) |=> !listening_o;
	endproperty
	a_unlisten: assert property (p_unlisten) else $error("unlisten ignored");

	property p_remote_enter;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && ren_i && acc_if.byte_stb && acc_if.byte_atn
			&& cmd == (`GL_LISTEN_GRP | {3'b000, addr_r})) |=> remote_o;
	endproperty
	a_remote_enter: assert property (p_remote_enter) else $error("remote not entered");

	property p_remote_needs_enable;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && !ren_i) |=> !remote_o;
	endproperty
	a_remote_needs_enable: assert property (p_remote_needs_enable) else $error("remote without enable");

	// An unaddressed port outside attention must keep both handshake lines released.
	property p_idle_off;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && !atn_i && !listening_r && nrfd_oe_n_o && ndac_oe_n_o) |=> (nrfd_oe_n_o && ndac_oe_n_o);
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("idle port joined handshake");

	property p_clear_quiet;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		(ce_i && ifc_i) |=> (!dev_clear_o && !trigger_o && !data_valid_o);
	endproperty
	a_clear_quiet: assert property (p_clear_quiet) else $error("pulse during interface clear");

	property p_data_stands;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		!(acc_if.byte_stb && !acc_if.byte_atn && listening_r && !ifc_i)
			|=> ($stable(data_o) && $stable(data_end_o));
	endproperty
	a_data_stands: assert property (p_data_stands) else $error("data changed without byte");
endmodule : gpib_listener

// file: testbench/gpib_talker_model.sv
// Behavioural controller and talker that sources bytes with the three-wire handshake.
module gpib_talker_model (
	input  wire logic  ref_clk_i,   // Bench clock.
	input  wire logic  nrfd_line_i, // Wired ready level, high when all release it.
	input  wire logic  ndac_line_i, // Wired accepted level, high when all release it.
	output logic [7:0] dio_o,       // Data lines.
	output logic       dav_o,       // Data valid.
	output logic       eoi_o,       // End mark.
	output logic       atn_o        // Attention.
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		dio_o = 8'h00;
		dav_o = 1'b0;
		eoi_o = 1'b0;
		atn_o = 1'b0;
	end
	// Ok drops if a handshake line misbehaves; slow holds data valid off for extra cycles.
	task automatic send(input logic [7:0] b, input logic atn, input logic eoi,
		input int slow, input logic part, output logic ok);
		int n;
		ok = 1'b1;
		atn_o = atn; // Sole controller and talker, one listener.
		repeat (2) begin
			@(posedge ref_clk_i);
			#1;
		end
		for (n = 0; n < 400 && nrfd_line_i !== 1'b1; n++) begin
			@(posedge ref_clk_i);
			#1;
		end
		repeat (slow) begin
			if (nrfd_line_i !== 1'b1) ok = 1'b0;
			@(posedge ref_clk_i);
			#1;
		end
		if (nrfd_line_i !== 1'b1) ok = 1'b0;
		dio_o = b;
		eoi_o = eoi;
		dav_o = 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (n < 400 && ndac_line_i !== 1'b1);
		if (ndac_line_i !== 1'b1) ok = 1'b0;
		dav_o = 1'b0;
		dio_o = ~b; // Released lines must not show a stale byte.
		eoi_o = ~eoi;
		if (part) begin
			for (n = 0; n < 400 && ndac_line_i !== 1'b0; n++) begin
				@(posedge ref_clk_i);
				#1;
			end
			if (ndac_line_i !== 1'b0) ok = 1'b0;
		end
	endtask : send
endmodule : gpib_talker_model

// file: testbench/tb_gpib_listener.sv
// Self-checking bench for the listen-only bus port.
module tb_gpib_listener;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [1:0] ctl; // Attention, end mark.
		logic [7:0] b;
		logic [4:0] exp; // Listening, remote, data, clear and trigger pulses.
	} row_t;
	logic       ref_clk_i, nrst_i, ifc, ren, urdy, ok, lis, dav, eoi, atn;
	logic       nrfd_oe_n, ndac_oe_n, dv, d_end, last_e, listening, remote, clr, trg;
	logic       nrfd_lvl, ndac_lvl;
	logic [7:0] dio, data, last_d;
	int         errors, cmp_count, dv_n, clr_n, trg_n, d0, c0, t0;
	row_t       rows [11];
	// The talker never pulls the handshake lines, so the wired level is the port's release.
	gpib_talker_model u_gpib_talker_model (.ref_clk_i(ref_clk_i), .nrfd_line_i(nrfd_oe_n),
		.ndac_line_i(ndac_oe_n), .dio_o(dio), .dav_o(dav), .eoi_o(eoi), .atn_o(atn));
	gpib_listener u_gpib_listener (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.addr_strap_i(5'h05), .dio_i(dio), .dav_i(dav), .eoi_i(eoi), .atn_i(atn),
		.ifc_i(ifc), .ren_i(ren), .user_ready_i(urdy), .nrfd_o(nrfd_lvl),
		.nrfd_oe_n_o(nrfd_oe_n), .ndac_o(ndac_lvl), .ndac_oe_n_o(ndac_oe_n),
		.data_o(data), .data_valid_o(dv),
		.data_end_o(d_end), .listening_o(listening), .remote_o(remote),
		.dev_clear_o(clr), .trigger_o(trg));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic wait_cy(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : wait_cy
	always @(posedge ref_clk_i) begin
		if (dv === 1'b1) begin
			dv_n++;
			last_d = data;
			last_e = d_end;
		end
		if (clr === 1'b1) clr_n++;
		if (trg === 1'b1) trg_n++;
	end
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#100_000;
		errors++;
		end_of_test();
	end
	initial begin
		{nrst_i, ifc, ren, urdy, lis} = 5'h06;
		rows = '{{2'h0, 8'h41, 5'h00}, {2'h2, 8'h25, 5'h18}, {2'h0, 8'h41, 5'h1C},
			{2'h1, 8'hC2, 5'h1C}, {2'h2, 8'h08, 5'h19}, {2'h2, 8'h04, 5'h1A},
			{2'h2, 8'h01, 5'h10}, {2'h2, 8'h14, 5'h12}, {2'h2, 8'hBF, 5'h00},
			{2'h0, 8'h55, 5'h00}, {2'h2, 8'h08, 5'h00}};
		wait_cy(5);
		chk({nrfd_oe_n, ndac_oe_n, listening, remote, dv, clr, trg, data}, 15'h6000);
		wait_cy(5);
		nrst_i = 1'b1;
		for (int i = 0; i < 11; i++) begin
			d0 = dv_n;
			c0 = clr_n;
			t0 = trg_n;
			u_gpib_talker_model.send(rows[i].b, rows[i].ctl[1], rows[i].ctl[0], 0,
				rows[i].ctl[1] | lis, ok);
			wait_cy(3);
			chk({31'h0, ok}, 32'h1);
			chk({listening, remote, dv_n != d0, clr_n != c0, trg_n != t0}, rows[i].exp);
			if (rows[i].exp[2]) chk({last_d, last_e}, {rows[i].b, rows[i].ctl[0]});
			lis = rows[i].exp[4];
		end
		// Slow sender, then a device byte held back until the consumer is ready.
		u_gpib_talker_model.send(8'h25, 1'b1, 1'b0, 6, 1'b1, ok);
		chk({31'h0, ok}, 32'h1);
		urdy = 1'b0;
		d0 = dv_n;
		fork
			u_gpib_talker_model.send(8'h66, 1'b0, 1'b0, 0, 1'b1, ok);
			begin
				wait_cy(20);
				chk({dv_n != d0, nrfd_oe_n}, 2'h0);
				urdy = 1'b1;
			end
		join
		wait_cy(3);
		chk({ok, dv_n == d0 + 1, last_d}, {1'b1, 1'b1, 8'h66});
		ren = 1'b0;
		wait_cy(3);
		chk({listening, remote}, 2'h2);
		ifc = 1'b1;
		wait_cy(2);
		ifc = 1'b0;
		d0 = dv_n;
		u_gpib_talker_model.send(8'h77, 1'b0, 1'b0, 0, 1'b0, ok);
		wait_cy(3);
		chk({listening, dv_n != d0}, 2'h0);
		// A reset in mid-run while addressed must bring back idle lines and clear the data.
		u_gpib_talker_model.send(8'h25, 1'b1, 1'b0, 0, 1'b1, ok);
		chk({ok, listening}, 2'h3);
		nrst_i = 1'b0;
		wait_cy(1);
		chk({nrfd_oe_n, ndac_oe_n, listening, remote, dv, clr, trg, data}, 15'h6000);
		chk({nrfd_lvl, ndac_lvl}, 2'h0);
		nrst_i = 1'b1;
		wait_cy(2);
		end_of_test();
	end
endmodule : tb_gpib_listener
